// ---- hdl/toc_pkg.sv ----
package toc_pkg;
  localparam logic [3:0] ADR_CTRL1 = 4'h0;
  localparam logic [3:0] ADR_CTRL2 = 4'h1;
  localparam logic [3:0] ADR_STATUS = 4'h2;
  localparam logic [3:0] ADR_CAP1_HI = 4'h3;
  localparam logic [3:0] ADR_CAP1_LO = 4'h4;
  localparam logic [3:0] ADR_CMP1_HI = 4'h5;
  localparam logic [3:0] ADR_CMP1_LO = 4'h6;
  localparam logic [3:0] ADR_CNT_HI = 4'h7;
  localparam logic [3:0] ADR_CNT_LO = 4'h8;
  localparam logic [3:0] ADR_ALT_HI = 4'h9;
  localparam logic [3:0] ADR_ALT_LO = 4'hA;
  localparam logic [3:0] ADR_CAP2_HI = 4'hB;
  localparam logic [3:0] ADR_CAP2_LO = 4'hC;
  localparam logic [3:0] ADR_CMP2_HI = 4'hD;
  localparam logic [3:0] ADR_CMP2_LO = 4'hE;
  // Control 1 fields
  localparam int C1_CAP_IRQ_EN = 7;
  localparam int C1_CMP_IRQ_EN = 6;
  localparam int C1_OVF_IRQ_EN = 5;
  localparam int C1_FORCE_2 = 4;
  localparam int C1_FORCE_1 = 3;
  localparam int C1_LEVEL_2 = 2;
  localparam int C1_EDGE_1 = 1;
  localparam int C1_LEVEL_1 = 0;
  // Control 2 fields
  localparam int C2_PIN_EN_1 = 7;
  localparam int C2_PIN_EN_2 = 6;
  localparam int C2_ONE_PULSE = 5;
  localparam int C2_PWM = 4;
  localparam int C2_CLK_SEL_HI = 3;
  localparam int C2_CLK_SEL_LO = 2;
  localparam int C2_EDGE_2 = 1;
  localparam int C2_EXT_EDGE = 0;
  // Flag vector positions; status byte is {flags, 3'b000}
  localparam int F_CAP1 = 4;
  localparam int F_CMP1 = 3;
  localparam int F_OVF = 2;
  localparam int F_CAP2 = 1;
  localparam int F_CMP2 = 0;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [15:0] CMP_RST = 16'h8000;
  localparam logic [15:0] CNT_RELOAD = 16'hFFFC;
  localparam logic [15:0] CAP_ONE_PULSE = 16'hFFFD;
  localparam logic [15:0] CNT_TOP = 16'hFFFF;
  localparam logic [1:0] CLK_DIV4 = 2'b00;
  localparam logic [1:0] CLK_DIV2 = 2'b01;
  localparam logic [1:0] CLK_DIV8 = 2'b10;
  localparam logic [1:0] CLK_EXT = 2'b11;
  localparam logic [2:0] DIV2_LAST = 3'h1;
  localparam logic [2:0] DIV4_LAST = 3'h3;
  localparam logic [2:0] DIV8_LAST = 3'h7;
endpackage

// ---- hdl/toc_timer.sv ----
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module toc_timer (
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic CAPTURE_PIN_1_I,
  input wire logic CAPTURE_PIN_2_I,
  input wire logic EXT_CLOCK_I,
  input wire logic GLOBAL_IRQ_MASK_I,
  output logic COMPARE_OUTPUT_PIN_1_O,
  output logic COMPARE_OUTPUT_PIN_1_OE_N_O,
  output logic COMPARE_OUTPUT_PIN_2_O,
  output logic COMPARE_OUTPUT_PIN_2_OE_N_O,
  output logic TIMER_IRQ_O
);
  import toc_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [4:0] flags;
    logic [4:0] armed;
    logic [1:0][15:0] cmp;
    logic [1:0][15:0] cap;
    logic [15:0] cnt;
    logic [7:0] cnt_buf;
    logic cnt_seq;
    logic [1:0] cmp_inh;
    logic [1:0] cap_inh;
    logic [1:0] pin_lat;
    logic [2:0] div_cnt;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic [7:0] rdata;
  } toc_state_s;

  localparam toc_state_s RESET_STATE = '{
    ctrl1: CTRL1_RST,
    ctrl2: CTRL2_RST,
    flags: 5'h00,
    armed: 5'h00,
    cmp: {CMP_RST, CMP_RST},
    cap: {16'h0000, 16'h0000},
    cnt: CNT_RELOAD,
    cnt_buf: 8'h00,
    cnt_seq: 1'b0,
    cmp_inh: 2'b00,
    cap_inh: 2'b00,
    pin_lat: 2'b00,
    div_cnt: 3'h0,
    sync1: 3'h0,
    sync2: 3'h0,
    sync3: 3'h0,
    rdata: 8'h00
  };

  toc_state_s state_ff;
  toc_state_s nxt_state;

  function automatic logic [2:0] div_last(input logic [1:0] sel);
    if (sel == CLK_DIV2) begin
      return DIV2_LAST;
    end else if (sel == CLK_DIV8) begin
      return DIV8_LAST;
    end else begin
      return DIV4_LAST;
    end
  endfunction

  function automatic int cmp_flag_pos(input int k);
    return (k == 0) ? F_CMP1 : F_CMP2;
  endfunction

  logic [1:0] clk_sel;
  logic tick;
  logic pwm_mode;
  logic pulse_mode;
  logic normal_mode;
  logic [2:0] rise;
  logic [2:0] fall;
  logic cap1_edge;
  logic cap2_edge;
  logic [15:0] cnt_inc;
  logic [1:0] match;
  logic [1:0] pin_en;
  logic [1:0] level;
  logic [4:0] set_flags;
  logic [4:0] touch;
  logic [4:0] wipe;
  logic status_rd;
  logic pulse_trig;

  always_comb begin
    clk_sel = state_ff.ctrl2[C2_CLK_SEL_HI:C2_CLK_SEL_LO];
    pwm_mode = state_ff.ctrl2[C2_PWM];
    pulse_mode = state_ff.ctrl2[C2_ONE_PULSE] & ~pwm_mode;
    normal_mode = ~pwm_mode & ~pulse_mode;
    rise = state_ff.sync2 & ~state_ff.sync3;
    fall = ~state_ff.sync2 & state_ff.sync3;
    if (clk_sel == CLK_EXT) begin
      // Edge spacing is the source's duty; closer edges merge
      tick = state_ff.ctrl2[C2_EXT_EDGE] ? rise[2] : fall[2];
    end else begin
      tick = (state_ff.div_cnt == div_last(clk_sel));
    end
    cnt_inc = state_ff.cnt + 16'h0001;
    pin_en = {state_ff.ctrl2[C2_PIN_EN_2], state_ff.ctrl2[C2_PIN_EN_1]};
    level = {state_ff.ctrl1[C1_LEVEL_2], state_ff.ctrl1[C1_LEVEL_1]};
    cap1_edge = state_ff.ctrl1[C1_EDGE_1] ? rise[0] : fall[0];
    cap2_edge = state_ff.ctrl2[C2_EDGE_2] ? rise[1] : fall[1];
    pulse_trig = pulse_mode & cap1_edge;
    status_rd = RD_I && (ADDR_I == ADR_STATUS);
    for (int k = 0; k < 2; k++) begin
      // Compared against the value the counter takes on this tick
      match[k] = tick && !state_ff.cmp_inh[k] && (cnt_inc == state_ff.cmp[k]);
    end
    touch = 5'h00;
    touch[F_CAP1] = (RD_I || WR_I) && (ADDR_I == ADR_CAP1_LO);
    touch[F_CMP1] = (RD_I || WR_I) && (ADDR_I == ADR_CMP1_LO);
    touch[F_OVF] = (RD_I || WR_I) && (ADDR_I == ADR_CNT_LO);
    touch[F_CAP2] = (RD_I || WR_I) && (ADDR_I == ADR_CAP2_LO);
    touch[F_CMP2] = (RD_I || WR_I) && (ADDR_I == ADR_CMP2_LO);
    wipe = state_ff.armed & touch;
  end

  always_comb begin
    nxt_state = state_ff;
    set_flags = 5'h00;
    nxt_state.rdata = 8'h00;
    nxt_state.sync1 = {EXT_CLOCK_I, CAPTURE_PIN_2_I, CAPTURE_PIN_1_I};
    nxt_state.sync2 = state_ff.sync1;
    nxt_state.sync3 = state_ff.sync2;
    nxt_state.div_cnt = (tick || clk_sel == CLK_EXT) ? 3'h0 : state_ff.div_cnt + 3'h1;

    if (tick) begin
      nxt_state.cnt = cnt_inc;
      if (state_ff.cnt == CNT_TOP) begin
        set_flags[F_OVF] = 1'b1;
      end
    end

    if (normal_mode) begin
      for (int k = 0; k < 2; k++) begin
        if (match[k]) begin
          set_flags[cmp_flag_pos(k)] = 1'b1;
          if (pin_en[k]) begin
            nxt_state.pin_lat[k] = level[k];
          end
        end
      end
    end else if (pulse_mode) begin
      if (match[0] && pin_en[0]) begin
        nxt_state.pin_lat[0] = level[0];
      end
      if (match[1]) begin
        set_flags[F_CMP2] = 1'b1;
      end
    end else begin
      // PWM: compare 2 closes the period and restarts the counter
      if (match[0] && pin_en[0]) begin
        nxt_state.pin_lat[0] = level[0];
      end
      if (match[1]) begin
        if (pin_en[0]) begin
          nxt_state.pin_lat[0] = level[1];
        end
        nxt_state.cnt = CNT_RELOAD;
        set_flags[F_CAP1] = 1'b1;
      end
    end

    if (pulse_trig) begin
      nxt_state.cnt = CNT_RELOAD;
      if (pin_en[0]) begin
        nxt_state.pin_lat[0] = level[1];
      end
      nxt_state.cap[0] = CAP_ONE_PULSE;
      set_flags[F_CAP1] = 1'b1;
    end else if (normal_mode && cap1_edge && !state_ff.cap_inh[0]) begin
      nxt_state.cap[0] = state_ff.cnt;
      set_flags[F_CAP1] = 1'b1;
    end
    if (cap2_edge && !state_ff.cap_inh[1]) begin
      nxt_state.cap[1] = state_ff.cnt;
      set_flags[F_CAP2] = 1'b1;
    end

    if (WR_I) begin
      if (ADDR_I == ADR_CTRL1) begin
        // Force bits act on the write in normal mode only and always read back as zero
        nxt_state.ctrl1 = WDATA_I & 8'hE7;
        if (normal_mode) begin
          if (WDATA_I[C1_FORCE_1] && pin_en[0]) begin
            nxt_state.pin_lat[0] = WDATA_I[C1_LEVEL_1];
          end
          if (WDATA_I[C1_FORCE_2] && pin_en[1]) begin
            nxt_state.pin_lat[1] = WDATA_I[C1_LEVEL_2];
          end
        end
      end else if (ADDR_I == ADR_CTRL2) begin
        nxt_state.ctrl2 = WDATA_I;
      end else if (ADDR_I == ADR_CMP1_HI) begin
        nxt_state.cmp[0][15:8] = WDATA_I;
        nxt_state.cmp_inh[0] = 1'b1;
      end else if (ADDR_I == ADR_CMP1_LO) begin
        nxt_state.cmp[0][7:0] = WDATA_I;
        nxt_state.cmp_inh[0] = 1'b0;
      end else if (ADDR_I == ADR_CMP2_HI) begin
        nxt_state.cmp[1][15:8] = WDATA_I;
        nxt_state.cmp_inh[1] = 1'b1;
      end else if (ADDR_I == ADR_CMP2_LO) begin
        nxt_state.cmp[1][7:0] = WDATA_I;
        nxt_state.cmp_inh[1] = 1'b0;
      end else if (ADDR_I == ADR_CNT_LO || ADDR_I == ADR_ALT_LO) begin
        nxt_state.cnt = CNT_RELOAD;
        nxt_state.div_cnt = 3'h0;
      end
    end

    if (RD_I) begin
      if (ADDR_I == ADR_CTRL1) begin
        nxt_state.rdata = state_ff.ctrl1;
      end else if (ADDR_I == ADR_CTRL2) begin
        nxt_state.rdata = state_ff.ctrl2;
      end else if (ADDR_I == ADR_STATUS) begin
        nxt_state.rdata = {state_ff.flags, 3'b000};
      end else if (ADDR_I == ADR_CAP1_HI) begin
        nxt_state.rdata = state_ff.cap[0][15:8];
        nxt_state.cap_inh[0] = 1'b1;
      end else if (ADDR_I == ADR_CAP1_LO) begin
        nxt_state.rdata = state_ff.cap[0][7:0];
        nxt_state.cap_inh[0] = 1'b0;
      end else if (ADDR_I == ADR_CAP2_HI) begin
        nxt_state.rdata = state_ff.cap[1][15:8];
        nxt_state.cap_inh[1] = 1'b1;
      end else if (ADDR_I == ADR_CAP2_LO) begin
        nxt_state.rdata = state_ff.cap[1][7:0];
        nxt_state.cap_inh[1] = 1'b0;
      end else if (ADDR_I == ADR_CMP1_HI) begin
        nxt_state.rdata = state_ff.cmp[0][15:8];
      end else if (ADDR_I == ADR_CMP1_LO) begin
        nxt_state.rdata = state_ff.cmp[0][7:0];
      end else if (ADDR_I == ADR_CMP2_HI) begin
        nxt_state.rdata = state_ff.cmp[1][15:8];
      end else if (ADDR_I == ADR_CMP2_LO) begin
        nxt_state.rdata = state_ff.cmp[1][7:0];
      end else if (ADDR_I == ADR_CNT_HI || ADDR_I == ADR_ALT_HI) begin
        // Low byte frozen so a two-byte read is coherent
        nxt_state.rdata = state_ff.cnt[15:8];
        nxt_state.cnt_buf = state_ff.cnt[7:0];
        nxt_state.cnt_seq = 1'b1;
      end else if (ADDR_I == ADR_CNT_LO || ADDR_I == ADR_ALT_LO) begin
        nxt_state.rdata = state_ff.cnt_seq ? state_ff.cnt_buf : state_ff.cnt[7:0];
        nxt_state.cnt_seq = 1'b0;
      end
    end

    // Set wins over a clear in the same cycle
    nxt_state.flags = (state_ff.flags & ~wipe) | set_flags;
    nxt_state.armed = (state_ff.armed & ~wipe) | (status_rd ? state_ff.flags : 5'h00);
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      state_ff <= RESET_STATE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign RDATA_O = state_ff.rdata;
  assign COMPARE_OUTPUT_PIN_1_O = state_ff.pin_lat[0];
  assign COMPARE_OUTPUT_PIN_2_O = state_ff.pin_lat[1];
  // Disabled pin is released to the port's general I/O use
  assign COMPARE_OUTPUT_PIN_1_OE_N_O = ~state_ff.ctrl2[C2_PIN_EN_1];
  assign COMPARE_OUTPUT_PIN_2_OE_N_O = ~state_ff.ctrl2[C2_PIN_EN_2];
  assign TIMER_IRQ_O = !GLOBAL_IRQ_MASK_I && (
      (state_ff.ctrl1[C1_CAP_IRQ_EN] && (state_ff.flags[F_CAP1] || state_ff.flags[F_CAP2])) ||
      (state_ff.ctrl1[C1_CMP_IRQ_EN] && (state_ff.flags[F_CMP1] || state_ff.flags[F_CMP2])) ||
      (state_ff.ctrl1[C1_OVF_IRQ_EN] && state_ff.flags[F_OVF]));

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_N_I);

  a_pin_reset_low: assert property (@(posedge CLOCK_I) disable iff (1'b0)
      !RST_N_I |=> (COMPARE_OUTPUT_PIN_1_O == 1'b0 && COMPARE_OUTPUT_PIN_2_O == 1'b0))
    else $error("compare pin latch not low after reset");

  a_cmp_reset_value: assert property (@(posedge CLOCK_I) disable iff (1'b0)
      !RST_N_I |=> (state_ff.cmp[0] == CMP_RST && state_ff.cmp[1] == CMP_RST && state_ff.cnt == CNT_RELOAD))
    else $error("compare or counter reset value wrong");

  a_match_sets_flag: assert property (
      (normal_mode && match[0] && !WR_I) |=> (state_ff.flags[F_CMP1] && state_ff.cnt == state_ff.cmp[0]))
    else $error("compare 1 match did not set flag with counter equal");

  a_match_drives_pin: assert property (
      (normal_mode && match[1] && pin_en[1] && !WR_I) |=> (COMPARE_OUTPUT_PIN_2_O == $past(level[1])))
    else $error("compare 2 match did not drive level");

  a_inhibit_blocks: assert property (
      (WR_I && ADDR_I == ADR_CMP1_HI) |=> (!match[0] throughout (state_ff.cmp_inh[0] [*1])))
    else $error("compare 1 matched while inhibited");

  a_no_cmp1_pulse: assert property (
      $rose(state_ff.flags[F_CMP1]) |-> $past(normal_mode))
    else $error("compare flag 1 set outside normal mode");

  a_pulse_trigger: assert property (
      (pulse_trig && !WR_I && pin_en[0]) |=>
      (state_ff.cnt == CNT_RELOAD && state_ff.cap[0] == CAP_ONE_PULSE && state_ff.flags[F_CAP1] &&
       COMPARE_OUTPUT_PIN_1_O == $past(level[1])))
    else $error("one pulse trigger effects missing");

  a_counter_reload: assert property (
      (WR_I && (ADDR_I == ADR_CNT_LO || ADDR_I == ADR_ALT_LO)) |=> state_ff.cnt == CNT_RELOAD)
    else $error("counter low write did not reload");

  a_flag_clear: assert property (
      (status_rd && state_ff.flags[F_CMP1]) ##1 (touch[F_CMP1] && !match[0]) |=> !state_ff.flags[F_CMP1])
    else $error("compare flag 1 not cleared by two step sequence");

  a_force_no_flag: assert property (
      (WR_I && ADDR_I == ADR_CTRL1 && WDATA_I[C1_FORCE_1] && normal_mode && pin_en[0] && !match[0]) |=>
      (COMPARE_OUTPUT_PIN_1_O == $past(WDATA_I[C1_LEVEL_1]) && $stable(state_ff.flags[F_CMP1])))
    else $error("forced output wrong or set flag");

  a_div2_spacing: assert property (
      (tick && clk_sel == CLK_DIV2 && !WR_I) ##1 !WR_I |-> !tick ##1 tick)
    else $error("divide by two tick spacing wrong");

  a_irq_on_flag: assert property (
      ($rose(state_ff.flags[F_CAP1]) && state_ff.ctrl1[C1_CAP_IRQ_EN] && !GLOBAL_IRQ_MASK_I) |-> TIMER_IRQ_O)
    else $error("capture flag 1 did not raise interrupt");

  a_pin_disabled_kept: assert property (
      (normal_mode && match[1] && !pin_en[1] && !WR_I) |=>
      ($stable(COMPARE_OUTPUT_PIN_2_O) && state_ff.flags[F_CMP2]))
    else $error("disabled compare pin 2 changed or flag missing");

  a_pulse_end_level: assert property (
      (pulse_mode && match[0] && pin_en[0] && !pulse_trig && !WR_I) |=>
      (COMPARE_OUTPUT_PIN_1_O == $past(level[0])))
    else $error("one pulse end level missing");

  a_cap2_in_pulse: assert property (
      (pulse_mode && cap2_edge && !state_ff.cap_inh[1]) |=>
      (state_ff.flags[F_CAP2] && state_ff.cap[1] == $past(state_ff.cnt)))
    else $error("capture 2 not working in one pulse mode");

  a_no_cap1_pulse: assert property (
      (pulse_mode && !pulse_trig) |=> $stable(state_ff.cap[0]))
    else $error("capture 1 loaded in one pulse mode");

  a_pulse_pin2_quiet: assert property (
      pulse_mode |=> $stable(COMPARE_OUTPUT_PIN_2_O))
    else $error("compare pin 2 changed in one pulse mode");

  a_force_ignored_mode: assert property (
      (WR_I && ADDR_I == ADR_CTRL1 && !normal_mode && !match[0] && !match[1] && !pulse_trig) |=>
      $stable(COMPARE_OUTPUT_PIN_1_O))
    else $error("force acted outside normal mode");

  a_flag_clear_gap: assert property (
      (status_rd && state_ff.flags[F_CMP1]) ##1 !touch[F_CMP1] ##1 (touch[F_CMP1] && !match[0]) |=>
      !state_ff.flags[F_CMP1])
    else $error("compare flag 1 not cleared after gap");

  c_pulse_trigger: cover property (pulse_trig);
  c_cmp_flag: cover property ($rose(state_ff.flags[F_CMP1]));
  c_pwm_period: cover property (pwm_mode && match[1]);
  c_overflow: cover property ($rose(state_ff.flags[F_OVF]));
endmodule

// ---- verif/toc_pin_partner.sv ----
`timescale 1ns/10ps
module toc_pin_partner (
  input wire logic clk_i,
  input wire logic pin_1_i,
  input wire logic oe_n_1_i,
  input wire logic pin_2_i,
  input wire logic oe_n_2_i,
  output logic cap_1_o,
  output logic cap_2_o,
  output logic ext_clk_o,
  output logic pad_1_o,
  output logic pad_2_o
);
  // Board pull-downs take the pads whenever the timer lets go
  assign pad_1_o = oe_n_1_i ? 1'b0 : pin_1_i;
  assign pad_2_o = oe_n_2_i ? 1'b0 : pin_2_i;
  initial begin
    cap_1_o = 1'b0;
    cap_2_o = 1'b0;
    ext_clk_o = 1'b0;
  end
  task automatic toggle_cap(input int which, input int hold);
    repeat (hold) @(posedge clk_i);
    if (which == 1) cap_1_o <= ~cap_1_o;
    else cap_2_o <= ~cap_2_o;
  endtask
  // Clock idles low between bursts; spacing never below four CPU clocks
  task automatic ext_edges(input int n, input int half);
    int h;
    h = (half < 4) ? 4 : half;
    for (int k = 0; k < n; k++) begin
      repeat (h) @(posedge clk_i);
      ext_clk_o <= 1'b1;
      repeat (h) @(posedge clk_i);
      ext_clk_o <= 1'b0;
    end
  endtask
endmodule

// ---- verif/toc_timer_bench.sv ----
`timescale 1ns/10ps
module toc_timer_bench;
  import toc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic gmask = 1'b0;
  logic [7:0] rdata, b;
  logic cap1, cap2, ext, pin1, oen1, pin2, oen2, irq, pad1, pad2;
  logic [15:0] v, e;
  int n_mismatch = 0;
  int check_count = 0;
  int mdl_cmp [2];
  int dv [3] = '{2, 4, 8};
  logic [1:0] sel [3];
  always #5 clk = ~clk;
  toc_timer i_toc_timer (.CLOCK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s),
    .RD_I(rd_s), .RDATA_O(rdata), .CAPTURE_PIN_1_I(cap1), .CAPTURE_PIN_2_I(cap2), .EXT_CLOCK_I(ext),
    .GLOBAL_IRQ_MASK_I(gmask), .COMPARE_OUTPUT_PIN_1_O(pin1), .COMPARE_OUTPUT_PIN_1_OE_N_O(oen1),
    .COMPARE_OUTPUT_PIN_2_O(pin2), .COMPARE_OUTPUT_PIN_2_OE_N_O(oen2), .TIMER_IRQ_O(irq));
  toc_pin_partner i_toc_pin_partner (.clk_i(clk), .pin_1_i(pin1), .oe_n_1_i(oen1), .pin_2_i(pin2),
    .oe_n_2_i(oen2), .cap_1_o(cap1), .cap_2_o(cap2), .ext_clk_o(ext), .pad_1_o(pad1), .pad_2_o(pad2));
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rd16(input logic [3:0] a, output logic [15:0] d);
    rd(a, d[15:8]);
    rd(4'(a + 4'h1), d[7:0]);
  endtask
  task automatic wr16(input logic [3:0] a, input logic [15:0] d);
    wr(a, d[15:8]);
    rd(ADR_STATUS, b);
    wr(4'(a + 4'h1), d[7:0]);
  endtask
  task automatic stat(input string name, input int pos, input logic exp);
    rd(ADR_STATUS, b);
    chk(name, 16'(exp), 16'(b[pos + 3]));
  endtask
  task automatic clr_flags();
    rd(ADR_STATUS, b);
    rd(ADR_CMP1_LO, b);
    rd(ADR_CMP2_LO, b);
    rd(ADR_CAP1_LO, b);
    rd(ADR_CAP2_LO, b);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    sel = '{CLK_DIV2, CLK_DIV4, CLK_DIV8};
    void'($urandom(32'h1c79a4fb));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk("pin1 reset", 16'h0000, 16'(pin1));
    chk("oe_n1 reset", 16'h0001, 16'(oen1));
    for (int i = 0; i < 2; i++) begin
      rd16(4'(ADR_CMP1_HI + 8 * i), v);
      chk("compare reset", CMP_RST, v);
      mdl_cmp[i] = 32'($urandom_range(16'h0018, 16'h0010)) - 8 * i;
      wr16(4'(ADR_CMP1_HI + 8 * i), 16'(mdl_cmp[i]));
      rd16(4'(ADR_CMP1_HI + 8 * i), v);
      chk("compare readback", 16'(mdl_cmp[i]), v);
    end
    rd(4'hF, b);
    chk("unmapped", 16'h0000, 16'(b));
    $display("test registers done");
    wr(ADR_CTRL1, 8'h01 << C1_CMP_IRQ_EN | 8'h01 << C1_LEVEL_1 | 8'h01 << C1_LEVEL_2);
    wr(ADR_CTRL2, 8'h01 << C2_PIN_EN_1 | {4'h0, CLK_DIV2, 2'b00});
    wr(ADR_CNT_LO, 8'h00);
    repeat (2 * (mdl_cmp[0] + 4) - 6) @(posedge clk);
    #1 chk("pin1 early", 16'h0000, 16'(pin1));
    repeat (12) @(posedge clk);
    #1 chk("pin1 match", 16'h0001, 16'(pin1));
    chk("pad2 unused", 16'h0000, 16'({pad2, oen2 ^ 1'b1}));
    chk("irq", 16'h0001, 16'(irq));
    @(posedge clk);
    gmask <= 1'b1;
    @(posedge clk);
    #1 chk("irq masked", 16'h0000, 16'(irq));
    @(posedge clk);
    gmask <= 1'b0;
    #1 chk("irq pending", 16'h0001, 16'(irq));
    // Low byte access before any status read must not clear
    rd(ADR_CMP1_LO, b);
    stat("cmp2 flag", F_CMP2, 1'b1);
    stat("cmp1 flag kept", F_CMP1, 1'b1);
    rd(ADR_CMP1_LO, b);
    stat("cmp1 flag cleared", F_CMP1, 1'b0);
    stat("cmp2 flag kept", F_CMP2, 1'b1);
    rd(ADR_CMP2_LO, b);
    #1 chk("irq cleared", 16'h0000, 16'(irq));
    $display("test compare match done");
    wr(ADR_CNT_LO, 8'h00);
    wr(ADR_CMP1_HI, 8'h00);
    repeat (2 * (mdl_cmp[0] + 12)) @(posedge clk);
    stat("cmp1 inhibited", F_CMP1, 1'b0);
    wr(ADR_CMP1_LO, 8'hC0);
    repeat (420) @(posedge clk);
    stat("cmp1 enabled", F_CMP1, 1'b1);
    clr_flags();
    wr(ADR_CTRL1, 8'h01 << C1_CMP_IRQ_EN | 8'h01 << C1_FORCE_1);
    repeat (3) @(posedge clk);
    #1 chk("forced low", 16'h0000, 16'({pin1, irq}));
    wr(ADR_CTRL1, 8'h01 << C1_CMP_IRQ_EN | 8'h01 << C1_FORCE_1 | 8'h01 << C1_LEVEL_1);
    repeat (3) @(posedge clk);
    #1 chk("forced high", 16'h0002, 16'({pin1, irq}));
    stat("force no flag", F_CMP1, 1'b0);
    $display("test inhibit and force done");
    for (int i = 0; i < 3; i++) begin
      wr(ADR_CTRL2, 8'h01 << C2_PIN_EN_1 | {4'h0, sel[i], 2'b00});
      wr(ADR_CNT_LO, 8'h00);
      repeat (96) @(posedge clk);
      rd16(ADR_CNT_HI, v);
      e = 16'(16'hFFFC + 96 / dv[i]);
      chk("prescaled count", e, v);
    end
    wr(ADR_CTRL2, 8'h01 << C2_PIN_EN_1 | {4'h0, CLK_EXT, 2'b01});
    wr(ADR_CNT_LO, 8'h00);
    i_toc_pin_partner.ext_edges(10, 5 + $urandom_range(3, 0));
    repeat (8) @(posedge clk);
    rd16(ADR_CNT_HI, v);
    chk("external count", 16'h0006, v);
    $display("test clock select done");
    wr(ADR_CTRL1, 8'h01 << C1_CAP_IRQ_EN | 8'h01 << C1_LEVEL_2 | 8'h01 << C1_EDGE_1);
    wr16(ADR_CMP1_HI, 16'h0020);
    wr(ADR_CTRL2, 8'h01 << C2_PIN_EN_1 | 8'h01 << C2_ONE_PULSE | 8'h01 << C2_EDGE_2 | {4'h0, CLK_DIV2, 2'b00});
    clr_flags();
    i_toc_pin_partner.toggle_cap(1, 1);
    repeat (8) @(posedge clk);
    #1 chk("pulse start", 16'h0003, 16'({pin1, irq}));
    rd16(ADR_CAP1_HI, v);
    chk("trigger capture", CAP_ONE_PULSE, v);
    repeat (30) @(posedge clk);
    #1 chk("pulse held", 16'h0001, 16'(pin1));
    repeat (40) @(posedge clk);
    #1 chk("pulse end", 16'h0000, 16'(pin1));
    stat("cmp1 quiet", F_CMP1, 1'b0);
    stat("cmp2 elapsed", F_CMP2, 1'b1);
    stat("cap1 flag", F_CAP1, 1'b1);
    rd(ADR_CAP1_LO, b);
    stat("cap1 cleared", F_CAP1, 1'b0);
    wr(ADR_CTRL1, 8'h01 << C1_LEVEL_2 | 8'h01 << C1_EDGE_1 | 8'h01 << C1_FORCE_1 | 8'h01 << C1_LEVEL_1);
    repeat (3) @(posedge clk);
    #1 chk("force ignored", 16'h0000, 16'(pin1));
    i_toc_pin_partner.toggle_cap(2, 1);
    repeat (8) @(posedge clk);
    stat("cap2 works", F_CAP2, 1'b1);
    $display("test one pulse done");
    // Both mode bits: compare 2 must restart the period as in PWM
    wr(ADR_CTRL2, 8'h01 << C2_PIN_EN_1 | 8'h01 << C2_ONE_PULSE | 8'h01 << C2_PWM | {4'h0, CLK_DIV2, 2'b00});
    wr(ADR_CNT_LO, 8'h00);
    clr_flags();
    repeat (2 * (mdl_cmp[1] + 8)) @(posedge clk);
    #1 chk("pwm pin", 16'h0001, 16'(pin1));
    stat("pwm restart", F_CAP1, 1'b1);
    stat("pwm no cmp flag", F_CMP2, 1'b0);
    $display("test mode priority done");
    give_verdict();
  end
endmodule
